// ===== bench/spc_host_model.sv
// Host controller model that writes control words over the serial link
`timescale 1ns/1ps
module spc_host_model
    import spc_pkg::*;
(
    input wire logic ref_clk_in, // Bench clock, paces the strobe
    output logic ser_data_out, // Serial data pin
    output logic ser_strobe_out, // Serial strobe, idle low between frames
    output logic data_frame_gate_n_out // Frame gate, low while shifting
);
    initial begin
        ser_data_out = 1'b0;
        ser_strobe_out = 1'b0;
        data_frame_gate_n_out = 1'b1;
    end

    // Half a strobe period of 80 ns
    task automatic half_period();
        repeat (5) @(posedge ref_clk_in);
        #1;
    endtask : half_period

    task automatic pulse();
        half_period();
        ser_strobe_out = 1'b1;
        half_period();
        ser_strobe_out = 1'b0;
    endtask : pulse

    // Tail below four lets a scenario leave the word unlatched
    task automatic send(input logic [15:0] word, input int tail);
        int i;
        data_frame_gate_n_out = 1'b0;
        for (i = WORD_W - 1; i >= 0; i--) begin
            ser_data_out = word[i];
            pulse();
        end
        // Released data line shows the inverse of its last value
        ser_data_out = ~word[0];
        data_frame_gate_n_out = 1'b1;
        for (i = 0; i < tail; i++) begin
            pulse();
        end
    endtask : send
endmodule : spc_host_model

// ===== bench/tb.sv
// Self-checking testbench for the control word 0 receiver
`timescale 1ns/1ps
module tb;
    import spc_pkg::*;
    localparam int POLL = 16;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ser_data, ser_strobe, gate_n;
    spc_detect_type det = '0;
    logic preamp_on_out, half_duplex_out, rx_mute_out, rx_agc_on_out;
    logic tx_suppress_out, coef_adapt_out, coef_zero_out;
    logic [1:0] aec_decay_out, nec_decay_out;
    logic [7:0] rx_gain_db_out;
    logic [3:0] rx_agc_ref_out;
    spc_word0_type word0_out;
    int failures = 0;
    int check_count = 0;

    always #4 ref_clk_in = ~ref_clk_in;

    spc_host_model host (.ref_clk_in(ref_clk_in), .ser_data_out(ser_data),
        .ser_strobe_out(ser_strobe), .data_frame_gate_n_out(gate_n));

    spc_word0 #(.POLL_CNT(POLL)) DUT (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .ser_data_in(ser_data), .ser_strobe_in(ser_strobe),
        .data_frame_gate_n_in(gate_n), .detect_in(det),
        .preamp_on_out(preamp_on_out), .half_duplex_out(half_duplex_out),
        .aec_decay_out(aec_decay_out), .nec_decay_out(nec_decay_out),
        .rx_gain_db_out(rx_gain_db_out), .rx_mute_out(rx_mute_out),
        .rx_agc_on_out(rx_agc_on_out), .rx_agc_ref_out(rx_agc_ref_out),
        .tx_suppress_out(tx_suppress_out), .coef_adapt_out(coef_adapt_out),
        .coef_zero_out(coef_zero_out), .word0_out(word0_out));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Write spaced by at least one poll interval plus sync latency
    task automatic wr(input logic [15:0] w, input int tail);
        host.send(w, tail);
        repeat (POLL + 8) @(posedge ref_clk_in);
        #1;
    endtask : wr

    task automatic set_det(input logic [3:0] d);
        det = d;
        repeat (2) @(posedge ref_clk_in);
        #1;
    endtask : set_det

    task automatic check_all(input logic [15:0] w);
        logic [3:0] v;
        logic [1:0] c;
        logic hd, ts;
        logic [7:0] g;
        v = w[11:8];
        g = VOL_MAX_DB - VOL_DB_STEP * v;
        c = w[6:5];
        hd = !w[14] && (det.training || det.howl_risk || c == 2'h1);
        ts = !w[7] && !det.near_speech && (!w[4] || det.rx_speech);
        cmp(16'(word0_out), 16'(w[15:4]));
        cmp(16'(preamp_on_out), 16'(w[15]));
        cmp(16'(half_duplex_out), 16'(hd));
        cmp(16'({aec_decay_out, nec_decay_out}),
            {12'h000, w[13:12], 2'h0});
        cmp(16'(rx_mute_out), 16'(v == VOL_MUTE));
        if (v != VOL_MUTE) begin
            cmp(16'(rx_gain_db_out), 16'(g));
        end
        cmp(16'({rx_agc_on_out, rx_agc_ref_out}),
            16'({v < VOL_UNITY, v}));
        cmp(16'(tx_suppress_out), 16'(ts));
        cmp(16'({coef_adapt_out, coef_zero_out}),
            16'({c == 2'h0 || c == 2'h3, c == 2'h1}));
    endtask : check_all

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        int i;
        int j;
        logic [15:0] cur;
        repeat (20) @(posedge ref_clk_in);
        #1;
        rst_in = 1'b0;
        @(posedge ref_clk_in);
        #1;
        check_all(WORD0_RESET);
        $display("test reset values done");
        for (i = 0; i < 16; i++) begin
            cur = {4'hA, i[3:0], 8'h00};
            wr(cur, 4);
            check_all(cur);
        end
        $display("test volume codes done");
        for (i = 0; i < 4; i++) begin
            cur = {i[1], 1'b0, i[1:0], 4'h4, 8'h00};
            wr(cur, 4);
            check_all(cur);
        end
        $display("test decay grade done");
        for (i = 0; i < 8; i++) begin
            cur = {1'b1, i[2], 2'h2, 4'h4, 1'b0, i[1:0], 5'h00};
            wr(cur, 4);
            check_all(cur);
        end
        $display("test coefficient control done");
        // Both suppression styles and both disable bits, checked against every detector flag combination
        for (i = 0; i < 8; i++) begin
            cur = {1'b1, i[0], 2'h2, 4'h4, i[1], 2'h0, i[2], 4'h0};
            wr(cur, 4);
            for (j = 0; j < 16; j++) begin
                set_det(j[3:0]);
                check_all(cur);
            end
            set_det(4'h0);
        end
        $display("test suppression and half-duplex done");
        wr(16'h5F02, 4);
        check_all(cur);
        wr(16'h5F01, 4);
        check_all(cur);
        wr(16'h3600, 3);
        check_all(cur);
        cur = 16'h3600;
        wr(cur, 4);
        check_all(cur);
        $display("test refused frames done");
        end_of_test();
    end

    initial begin
        #400000;
        failures++;
        $display("ERROR t=%0t watchdog expired", $time);
        end_of_test();
    end
endmodule : tb

// ===== src/spc_pkg.sv
// Package: constants and types for the speakerphone control word 0 block
package spc_pkg;

    // --------------------------------------------------------------
    // Control word layout
    // --------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_WORD0 = 4'h0;
    localparam int POS_PREAMP = 15;
    localparam int POS_HDOFF = 14;
    localparam int POS_DECAY_HI = 13;
    localparam int POS_DECAY_LO = 12;
    localparam int POS_VOL_HI = 11;
    localparam int POS_VOL_LO = 8;
    localparam int POS_TSOFF = 7;
    localparam int POS_COEF_HI = 6;
    localparam int POS_COEF_LO = 5;
    localparam int POS_STYLE = 4;
    localparam int TAIL_PULSES = 4;

    // --------------------------------------------------------------
    // Reset values and codes
    // --------------------------------------------------------------
    localparam logic [15:0] WORD0_RESET = 16'hA400;
    localparam logic [3:0] VOL_UNITY = 4'hA;
    localparam logic [3:0] VOL_MUTE = 4'hF;
    localparam logic [3:0] VOL_DB_STEP = 4'h3;
    localparam logic [7:0] VOL_MAX_DB = 8'h1E;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int POLL_PERIOD_NS = 125000;
    localparam int POLL_CYCLES = (POLL_PERIOD_NS * 1000) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        COEF_NORMAL = 2'b00,
        COEF_CLEAR = 2'b01,
        COEF_FREEZE = 2'b10,
        COEF_RSVD = 2'b11
    } spc_coef_type;

    typedef enum logic [1:0] {
        DECAY_NONE = 2'b00,
        DECAY_075 = 2'b01,
        DECAY_038 = 2'b10,
        DECAY_019 = 2'b11
    } spc_decay_type;

    typedef struct packed {
        logic preamp_on;
        logic half_duplex_off;
        spc_decay_type echo_decay_grade;
        logic [3:0] rx_volume_level;
        logic tx_suppress_off;
        spc_coef_type acoustic_coef_ctrl;
        logic tx_suppress_style;
    } spc_word0_type;

    typedef struct packed {
        logic rx_speech;
        logic near_speech;
        logic training;
        logic howl_risk;
    } spc_detect_type;

endpackage : spc_pkg

// ===== src/spc_word0.sv
// Module: serial control word 0 receiver and speech path control decode
`timescale 1ns/1ps
module spc_word0
    import spc_pkg::*;
#(
    parameter int POLL_CNT = POLL_CYCLES
) (
    input wire logic ref_clk_in, // System clock
    input wire logic rst_in, // Synchronous reset
    input wire logic ser_data_in, // Serial data pin
    input wire logic ser_strobe_in, // Serial strobe pin
    input wire logic data_frame_gate_n_in, // Frame gate, low while shifting
    input wire spc_detect_type detect_in, // Speech detector flags
    output logic preamp_on_out, // Mic preamp enable
    output logic half_duplex_out, // Half-duplex operation
    output logic [1:0] aec_decay_out, // Decay grade to acoustic canceller
    output logic [1:0] nec_decay_out, // Network canceller decay, always none
    output logic [7:0] rx_gain_db_out, // Receive gain, signed dB
    output logic rx_mute_out, // Receive path muted
    output logic rx_agc_on_out, // Receive AGC enabled
    output logic [3:0] rx_agc_ref_out, // AGC reference code
    output logic tx_suppress_out, // Transmit suppression attenuating
    output logic coef_adapt_out, // Acoustic coefficients adapt
    output logic coef_zero_out, // Acoustic coefficients held at zero
    output spc_word0_type word0_out // Current control word 0
);

    if (POLL_CNT < 2) begin : g_poll_check
        $error("POLL_CNT too small");
    end

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    logic [2:0] sync1_q, sync1_d, sync2_q, sync2_d;
    logic strobe_prev_q, strobe_prev_d;
    logic strobe_rise;

    always_comb begin
        sync1_d = {ser_data_in, ser_strobe_in, data_frame_gate_n_in};
        sync2_d = sync1_q;
        strobe_prev_d = sync2_q[1];
        strobe_rise = sync2_q[1] & ~strobe_prev_q;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            // Idle pin levels, so no false strobe edge follows reset
            sync1_q <= 3'h1;
            sync2_q <= 3'h1;
            strobe_prev_q <= 1'b0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            strobe_prev_q <= strobe_prev_d;
        end
    end

    // --------------------------------------------------------------
    // Shift register and tail pulse counter
    // --------------------------------------------------------------
    logic [WORD_W-1:0] shift_q, shift_d;
    logic [2:0] tail_q, tail_d;
    logic pend_q, pend_d;
    logic [WORD_W-1:0] pend_word_q, pend_word_d;
    logic gate_n;
    logic take_word;

    assign gate_n = sync2_q[0];

    always_comb begin
        shift_d = shift_q;
        tail_d = tail_q;
        take_word = 1'b0;
        if (strobe_rise) begin
            if (!gate_n) begin
                shift_d = {shift_q[WORD_W-2:0], sync2_q[2]};
                tail_d = 3'h0;
            end else if (tail_q < 3'(TAIL_PULSES)) begin
                tail_d = tail_q + 3'h1;
                take_word = (tail_q == 3'(TAIL_PULSES - 1));
            end
        end
    end

    // --------------------------------------------------------------
    // Poll timer: pending word reaches the register on a poll tick
    // --------------------------------------------------------------
    logic [$clog2(POLL_CNT)-1:0] poll_q, poll_d;
    logic poll_tick;
    spc_word0_type word_q, word_d;
    logic addr_ok;

    always_comb begin
        poll_tick = (poll_q == '0);
        poll_d = poll_tick ? ($clog2(POLL_CNT))'(POLL_CNT - 1)
                           : poll_q - 1'b1;
        pend_d = pend_q;
        pend_word_d = pend_word_q;
        if (take_word) begin
            pend_d = 1'b1;
            pend_word_d = shift_q;
        end else if (poll_tick) begin
            pend_d = 1'b0;
        end
        addr_ok = (pend_word_q[ADDR_W-1:0] == ADDR_WORD0);
        word_d = word_q;
        if (poll_tick && pend_q && addr_ok) begin
            word_d = spc_word0_type'(pend_word_q[WORD_W-1:ADDR_W]);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            shift_q <= '0;
            tail_q <= 3'(TAIL_PULSES);
            pend_q <= 1'b0;
            pend_word_q <= '0;
            poll_q <= '0;
            word_q <= spc_word0_type'(WORD0_RESET[WORD_W-1:ADDR_W]);
        end else begin
            shift_q <= shift_d;
            tail_q <= tail_d;
            pend_q <= pend_d;
            pend_word_q <= pend_word_d;
            poll_q <= poll_d;
            word_q <= word_d;
        end
    end

    // --------------------------------------------------------------
    // Speech path decode
    // --------------------------------------------------------------
    logic preamp_d, hd_d, agc_d, mute_d, tsup_d, adapt_d, zero_d;
    logic [1:0] decay_d;
    logic [7:0] gain_d;
    logic coef_clear;
    logic engage;
    logic preamp_q, hd_q, agc_q, mute_q, tsup_q, adapt_q, zero_q;
    logic [1:0] decay_q;
    logic [7:0] gain_q;

    always_comb begin
        preamp_d = word_q.preamp_on;
        coef_clear = (word_q.acoustic_coef_ctrl == COEF_CLEAR);
        hd_d = !word_q.half_duplex_off && (detect_in.training
               || detect_in.howl_risk || coef_clear);
        decay_d = word_q.echo_decay_grade;
        gain_d = VOL_MAX_DB
                 - 8'(word_q.rx_volume_level) * 8'(VOL_DB_STEP);
        mute_d = (word_q.rx_volume_level == VOL_MUTE);
        agc_d = (word_q.rx_volume_level < VOL_UNITY);
        if (word_q.tx_suppress_style) begin
            engage = detect_in.rx_speech && !detect_in.near_speech;
        end else begin
            engage = !detect_in.near_speech;
        end
        tsup_d = !word_q.tx_suppress_off && engage;
        unique case (word_q.acoustic_coef_ctrl)
            COEF_NORMAL: begin
                adapt_d = 1'b1;
                zero_d = 1'b0;
            end
            COEF_CLEAR: begin
                adapt_d = 1'b0;
                zero_d = 1'b1;
            end
            COEF_FREEZE: begin
                adapt_d = 1'b0;
                zero_d = 1'b0;
            end
            COEF_RSVD: begin
                adapt_d = 1'b1;
                zero_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            preamp_q <= 1'b1;
            hd_q <= 1'b0;
            decay_q <= DECAY_038;
            gain_q <= 8'h12;
            mute_q <= 1'b0;
            agc_q <= 1'b1;
            tsup_q <= 1'b0;
            adapt_q <= 1'b1;
            zero_q <= 1'b0;
        end else begin
            preamp_q <= preamp_d;
            hd_q <= hd_d;
            decay_q <= decay_d;
            gain_q <= gain_d;
            mute_q <= mute_d;
            agc_q <= agc_d;
            tsup_q <= tsup_d;
            adapt_q <= adapt_d;
            zero_q <= zero_d;
        end
    end

    assign preamp_on_out = preamp_q;
    assign half_duplex_out = hd_q;
    assign aec_decay_out = decay_q;
    assign nec_decay_out = DECAY_NONE;
    assign rx_gain_db_out = gain_q;
    assign rx_mute_out = mute_q;
    assign rx_agc_on_out = agc_q;
    assign rx_agc_ref_out = word_q.rx_volume_level;
    assign tx_suppress_out = tsup_q;
    assign coef_adapt_out = adapt_q;
    assign coef_zero_out = zero_q;
    assign word0_out = word_q;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    sequence s_tail_done;
        take_word;
    endsequence
    sequence s_word_pending;
        pend_q;
    endsequence

    a_clear_forces_hd: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) (coef_clear && !word_q.half_duplex_off) |=> hd_q)
        else $error("clear did not force half-duplex");
    a_hd_off_blocks: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) word_q.half_duplex_off |=> !hd_q)
        else $error("half-duplex while disabled");
    a_near_release: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) detect_in.near_speech |=> !tsup_q)
        else $error("suppression held during near speech");
    a_style_one_gate: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) (word_q.tx_suppress_style && !detect_in.rx_speech)
        |=> !tsup_q)
        else $error("style one engaged without rx speech");
    a_style_zero_eng: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) (!word_q.tx_suppress_style && !word_q.tx_suppress_off
        && !detect_in.near_speech) |=> tsup_q)
        else $error("noise squelch not engaged");
    a_mute_code: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) mute_q |-> (gain_q == 8'hF1))
        else $error("mute gain not -15 code");
    a_agc_unity: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) (rx_agc_ref_out == VOL_UNITY) |=> !agc_q)
        else $error("AGC on at unity");
    a_clear_zero: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) (word_q.acoustic_coef_ctrl == COEF_CLEAR)
        |=> (zero_q && !adapt_q))
        else $error("clear not holding zero");
    a_tail_latch: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) s_tail_done |=> s_word_pending)
        else $error("word not pending after tail");
    a_addr_refuse: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) (poll_tick && pend_q && !addr_ok) |=> $stable(word_q))
        else $error("word for another register applied");
    a_poll_gap: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) poll_tick |=> !poll_tick)
        else $error("poll ticks back to back");
    a_mute_agc_off: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) mute_q |-> !agc_q)
        else $error("AGC on while muted");
    a_agc_loud: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) (rx_agc_ref_out < VOL_UNITY) |=> agc_q)
        else $error("AGC off above unity");
    a_preamp_follow: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) word_q.preamp_on |=> preamp_q)
        else $error("preamp not enabled");
    a_hd_needs_cause: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) (!detect_in.training && !detect_in.howl_risk
        && !coef_clear) |=> !hd_q)
        else $error("half-duplex without cause");
    a_zero_quiet: assert property (@(posedge ref_clk_in) disable iff
        (rst_in) (word_q.acoustic_coef_ctrl != COEF_CLEAR)
        |=> !zero_q)
        else $error("coefficients zeroed without clear");

endmodule : spc_word0
